/* File: sdlct_pkg.sv */
// constants and types for the sdlc frame transmitter
package sdlct_pkg;

  // ==========================================================
  // register pointers and commands
  localparam logic [2:0] PTR_CMD       = 3'h0;
  localparam logic [2:0] PTR_INT_CFG   = 3'h1;
  localparam logic [2:0] PTR_MODE      = 3'h4;
  localparam logic [2:0] PTR_TX_CTRL   = 3'h5;
  localparam int         CMD_LO        = 3;
  localparam int         CMD_HI        = 5;
  localparam int         RST_LO        = 6;
  localparam int         RST_HI        = 7;
  localparam logic [2:0] CMD_ABORT     = 3'h1;
  localparam logic [2:0] CMD_RST_EXT   = 3'h2;
  localparam logic [2:0] CMD_CHAN_RST  = 3'h3;
  localparam logic [2:0] CMD_RST_TXINT = 3'h5;
  localparam logic [1:0] RST_CRC_GEN   = 2'h1;
  localparam logic [1:0] RST_EOM       = 2'h3;

  // ==========================================================
  // field positions
  localparam int         IC_EXT_EN     = 0;
  localparam int         IC_TX_EN      = 1;
  localparam int         IC_WR_READY   = 5;
  localparam int         IC_WR_EN      = 7;
  localparam int         MC_MODE_LO    = 4;
  localparam int         MC_MODE_HI    = 5;
  localparam logic [1:0] MODE_SDLC     = 2'h2;
  localparam int         TC_CRC_EN     = 0;
  localparam int         TC_RTS        = 1;
  localparam int         TC_TX_EN      = 3;
  localparam int         TC_BREAK      = 4;
  localparam int         TC_LEN_LO     = 5;
  localparam int         TC_LEN_HI     = 6;
  localparam int         TC_DTR        = 7;
  localparam int         ST_TX_EMPTY   = 2;
  localparam int         ST_INT_PEND   = 1;
  localparam int         ST_EOM        = 6;

  // ==========================================================
  // characters and counts
  localparam logic [7:0]  FLAG_CHAR    = 8'h7e;
  localparam logic [7:0]  ABORT_CHAR   = 8'hff;
  localparam logic [7:0]  MARK_CHAR    = 8'hff;
  localparam logic [15:0] CRC_PRESET   = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [2:0]  STUFF_RUN    = 3'h5;
  localparam logic [3:0]  LEN_8        = 4'h8;
  localparam logic [3:0]  LEN_7        = 4'h7;
  localparam logic [3:0]  LEN_6        = 4'h6;
  localparam logic [3:0]  LEN_5        = 4'h5;
  localparam logic [3:0]  LEN_MARK     = 4'h1;

  // ==========================================================
  // character kinds on the line
  typedef enum logic [2:0] {
    K_MARK  = 3'h0,
    K_FLAG  = 3'h1,
    K_DATA  = 3'h3,
    K_CRC1  = 3'h2,
    K_CRC2  = 3'h6,
    K_ABORT = 3'h7
  } sdlct_kind_t;

endpackage : sdlct_pkg

/* File: sdlct_crc_if.sv */
// link between the bit engine and the check generator
`timescale 1ns/1ps
interface sdlct_crc_if;
  logic        preset;
  logic        shift_en;
  logic        bit_in;
  logic [15:0] crc;
  modport eng  (output preset, output shift_en, output bit_in, input crc);
  modport calc (input preset, input shift_en, input bit_in, output crc);
endinterface : sdlct_crc_if

/* File: sdlct_crc16.sv */
// frame check generator, lsb first
`timescale 1ns/1ps
module sdlct_crc16
  import sdlct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  sdlct_crc_if.calc crc_io
);

  logic [15:0] crc_q;
  logic        fb;

  assign fb         = crc_q[0] ^ crc_io.bit_in;
  assign crc_io.crc = crc_q;

  // ==========================================================
  // (R18) preset to all ones
  always_ff @(posedge core_clk) begin
    if (!rst_n || crc_io.preset) begin
      crc_q <= CRC_PRESET;
    end else if (crc_io.shift_en) begin
      crc_q <= (crc_q >> 1) ^ (fb ? CRC_POLY : 16'h0000);
    end
  end

  // (R18) preset reaches all ones
  preset_ones_a : assert property (                          // R18
    @(posedge core_clk) disable iff (!rst_n)
    crc_io.preset |=> crc_q == CRC_PRESET)
    else $error("check generator not preset");

endmodule : sdlct_crc16

/* File: sdlct_frame_tx.sv */
// sdlc frame transmitter: registers, bit engine, pacing
//
// Notes on behaviour
// (R01) line marks after reset or disabled
// (R02) break forces a spacing line
// (R03) idle enabled transmitter sends back to back flags
// (R04) abort sends 8 to 13 ones, drops data
// (R05) zero after five ones, data and check characters only
// (R06) interrupt when buffer goes full to empty
// (R07) reset pending command stops interrupts, underrun follows
// (R08) no empty interrupt before first write
// (R09) wait stretches writes, ready while empty
// (R10) empty shifter with no data is underrun
// (R11) underrun with latch clear sends check bytes
// (R12) latch set at reset, underrun gives flags
// (R13) check bytes set latch, clear empty status
// (R14) host clears latch within each frame
// (R15) after check bytes flag loads, empty interrupt
// (R16) underrun setting latch raises status interrupt
// (R17) check then flag gives abort window
// (R18) host presets check generator each frame
// (R19) check covers frame characters, sent inverted
// (R20) at least one flag after enable
// (R21) host sets check enable before address
// (R22) length code picks 5, 7, 6, 8 bits
// (R23) characters leave least significant bit first
// (R24) no shared zero flags
// (R25) disable finishes character, then marks
// (R26) flag is 01111110 without stuffing
`timescale 1ns/1ps
module sdlct_frame_tx
  import sdlct_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic       cpu_cd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            wait_n,
  output logic            ready_n,
  output logic            tx_irq,
  output logic            ext_irq,
  input  wire logic       txc,
  output logic            txd,
  output logic            rts_n,
  output logic            dtr_n
);

  // ==========================================================
  // state
  logic [2:0]  ptr_q;
  logic [7:0]  int_cfg_q;
  logic [7:0]  mode_q;
  logic [7:0]  txctl_q;
  logic [7:0]  buf_q;
  logic        buf_full_q;
  logic        tx_pend_q;
  logic        ext_pend_q;
  logic        eom_q;
  logic        crc_busy_q;
  logic        abort_q;
  sdlct_kind_t kind_q;
  logic [7:0]  sh_q;
  logic [3:0]  left_q;
  logic [2:0]  ones_q;
  logic        acc_q;
  logic        bit_q;
  logic [7:0]  crc_hi_q;
  logic [7:0]  rdata_q;
  logic        txc_s1_q;
  logic        txc_s2_q;
  logic        txc_s3_q;

  // ==========================================================
  // cpu decode
  logic       wr_ctrl;
  logic       wr_data_req;
  logic       wr_block;
  logic       wr_data;
  logic       cmd_sel;
  logic [2:0] cmd;
  logic [1:0] rst_code;
  logic       soft_rst;
  logic       clr;
  logic       cmd_abort;
  logic       cmd_rst_ext;
  logic       cmd_rst_txint;
  logic       cmd_rst_crc;
  logic       cmd_rst_eom;
  logic       tx_on;
  logic       tx_empty;

  assign wr_ctrl       = cpu_wr & cpu_cd;
  assign wr_data_req   = cpu_wr & ~cpu_cd;
  assign wr_block      = int_cfg_q[IC_WR_EN] & ~int_cfg_q[IC_WR_READY]
                         & buf_full_q;
  assign wr_data       = wr_data_req & ~wr_block;
  assign cmd_sel       = wr_ctrl & (ptr_q == PTR_CMD);
  assign cmd           = cpu_wdata[CMD_HI:CMD_LO];
  assign rst_code      = cpu_wdata[RST_HI:RST_LO];
  assign soft_rst      = cmd_sel & (cmd == CMD_CHAN_RST);
  assign clr           = ~rst_n | soft_rst;
  assign cmd_abort     = cmd_sel & (cmd == CMD_ABORT);
  assign cmd_rst_ext   = cmd_sel & (cmd == CMD_RST_EXT);
  assign cmd_rst_txint = cmd_sel & (cmd == CMD_RST_TXINT);
  assign cmd_rst_crc   = cmd_sel & (rst_code == RST_CRC_GEN);
  assign cmd_rst_eom   = cmd_sel & (rst_code == RST_EOM);
  assign tx_on         = txctl_q[TC_TX_EN]
                         & (mode_q[MC_MODE_HI:MC_MODE_LO] == MODE_SDLC);
  assign tx_empty      = ~buf_full_q & ~crc_busy_q;

  // ==========================================================
  // registers and commands
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ptr_q <= PTR_CMD;
    end else if (wr_ctrl) begin
      ptr_q <= (ptr_q == PTR_CMD) ? cpu_wdata[2:0] : PTR_CMD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      int_cfg_q <= 8'h00;
      mode_q    <= 8'h00;
      txctl_q   <= 8'h00;
    end else if (wr_ctrl) begin
      if (ptr_q == PTR_INT_CFG) int_cfg_q <= cpu_wdata;
      if (ptr_q == PTR_MODE)    mode_q    <= cpu_wdata;
      if (ptr_q == PTR_TX_CTRL) txctl_q   <= cpu_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_data) begin
      buf_q <= cpu_wdata;
    end
  end

  // ==========================================================
  // link clock sampling, falling edge shifts
  logic tick;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txc_s1_q <= 1'b1;
      txc_s2_q <= 1'b1;
      txc_s3_q <= 1'b1;
    end else begin
      txc_s1_q <= txc;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
    end
  end

  assign tick = txc_s3_q & ~txc_s2_q;

  // ==========================================================
  // bit engine decode
  logic        stuffable;
  logic        stuff_need;
  logic        abort_go;
  logic        load;
  logic        shift;
  logic        stuff;
  logic        underrun;
  logic        crc_done;
  logic        data_take;
  logic        out_bit;
  sdlct_kind_t nk;
  logic [7:0]  nch;
  logic [3:0]  nlen;
  logic [3:0]  data_len;
  logic [15:0] crc_val;

  // (R05) only data and check characters are stuffed
  assign stuffable  = (kind_q == K_DATA) | (kind_q == K_CRC1)
                      | (kind_q == K_CRC2);
  assign stuff_need = stuffable & (ones_q == STUFF_RUN);
  // (R04) abort cuts in, run stays under fourteen
  assign abort_go   = abort_q & ~((kind_q == K_FLAG) & (ones_q > STUFF_RUN));
  assign load       = tick & (abort_go | (~stuff_need & (left_q == 4'h0)));
  assign shift      = tick & ~abort_go & ~stuff_need & (left_q != 4'h0);
  assign stuff      = tick & ~abort_go & stuff_need;
  // (R10) shifter empty with nothing buffered
  assign underrun   = load & ~abort_q & tx_on & (kind_q == K_DATA)
                      & ~buf_full_q;
  // (R17) check bytes, then flag
  assign crc_done   = load & (kind_q == K_CRC2) & (nk == K_FLAG);
  assign data_take  = load & (nk == K_DATA);

  // (R22) character length code
  assign data_len = (txctl_q[TC_LEN_HI:TC_LEN_LO] == 2'h0) ? LEN_5 :
                    (txctl_q[TC_LEN_HI:TC_LEN_LO] == 2'h1) ? LEN_7 :
                    (txctl_q[TC_LEN_HI:TC_LEN_LO] == 2'h2) ? LEN_6 : LEN_8;

  // next character, in priority order
  always_comb begin
    nk   = K_FLAG;
    // (R24) (R26) whole unstuffed flags
    nch  = FLAG_CHAR;
    nlen = LEN_8;
    if (abort_q) begin
      // (R04) eight ones, no stuffing
      nk  = K_ABORT;
      nch = ABORT_CHAR;
    end else if (!tx_on) begin
      // (R25) finish character, then mark
      nk   = K_MARK;
      nch  = MARK_CHAR;
      nlen = LEN_MARK;
    end else if (kind_q == K_MARK) begin
      // (R20) first character after enable is a flag
      nk = K_FLAG;
    end else if (kind_q == K_CRC1) begin
      // (R11) both check bytes go out
      nk  = K_CRC2;
      nch = crc_hi_q;
    end else if (buf_full_q) begin
      nk   = K_DATA;
      nch  = buf_q;
      nlen = data_len;
    end else if ((kind_q == K_DATA) && !eom_q) begin
      // (R11) close frame with inverted check, low byte first
      nk  = K_CRC1;
      nch = ~crc_val[7:0];
    end
  end

  // (R23) least significant bit first
  assign out_bit = load ? nch[0] : (shift ? sh_q[0] : 1'b0);

  // ==========================================================
  // bit engine state
  always_ff @(posedge core_clk) begin
    if (clr) begin
      kind_q <= K_MARK;
      sh_q   <= MARK_CHAR;
      left_q <= 4'h0;
      acc_q  <= 1'b0;
    end else if (load) begin
      // (R03) idle enabled line repeats whole flags
      kind_q <= nk;
      sh_q   <= nch >> 1;
      left_q <= nlen - 4'h1;
      acc_q  <= (nk == K_DATA) & txctl_q[TC_CRC_EN];
    end else if (shift) begin
      sh_q   <= sh_q >> 1;
      left_q <= left_q - 4'h1;
    end
  end

  // (R05) count ones; loading a flag, mark or abort restarts the count at zero
  always_ff @(posedge core_clk) begin
    if (clr || stuff) begin
      ones_q <= 3'h0;
    end else if (load) begin
      ones_q <= ((nk == K_DATA || nk == K_CRC1 || nk == K_CRC2) && out_bit)
                ? ones_q + 3'h1 : 3'h0;
    end else if (shift) begin
      ones_q <= out_bit ? ones_q + 3'h1 : 3'h0;
    end
  end

  // (R01) line idles at one
  always_ff @(posedge core_clk) begin
    if (clr) begin
      bit_q <= 1'b1;
    end else if (tick) begin
      bit_q <= out_bit;
    end
  end

  // (R19) high check byte kept inverted for the second slot
  always_ff @(posedge core_clk) begin
    if (clr) begin
      crc_hi_q <= 8'h00;
    end else if (load && nk == K_CRC1) begin
      crc_hi_q <= ~crc_val[15:8];
    end
  end

  // (R02) break overrides the line
  assign txd   = txctl_q[TC_BREAK] ? 1'b0 : bit_q;
  assign rts_n = ~txctl_q[TC_RTS];
  assign dtr_n = ~txctl_q[TC_DTR];

  // ==========================================================
  // check generator
  sdlct_crc_if crc_link ();

  // (R19) every frame character bit is accumulated
  assign crc_link.preset   = cmd_rst_crc;
  assign crc_link.shift_en = (load & (nk == K_DATA) & txctl_q[TC_CRC_EN])
                             | (shift & acc_q);
  assign crc_link.bit_in   = out_bit;
  assign crc_val           = crc_link.crc;

  sdlct_crc16 u_crc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .crc_io   (crc_link.calc)
  );

  // ==========================================================
  // buffer, latch and interrupt flags; set wins over clear, except that abort wins over a buf_full_q or crc_busy_q set
  always_ff @(posedge core_clk) begin
    if (clr || cmd_abort) begin
      // (R04) abort drops the buffered character
      buf_full_q <= 1'b0;
    end else if (wr_data) begin
      buf_full_q <= 1'b1;
    end else if (data_take) begin
      buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      abort_q <= 1'b0;
    end else if (cmd_abort) begin
      abort_q <= 1'b1;
    end else if (tick && abort_go) begin
      abort_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      // (R12) latch set from reset
      eom_q <= 1'b1;
    end else if (underrun && !eom_q) begin
      // (R13) check bytes start, latch set again
      eom_q <= 1'b1;
    end else if (cmd_rst_eom) begin
      eom_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr || cmd_abort) begin
      crc_busy_q <= 1'b0;
    end else if (load && nk == K_CRC1) begin
      // (R13) shifter holds check data
      crc_busy_q <= 1'b1;
    end else if (load) begin
      crc_busy_q <= (nk == K_CRC2);
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      tx_pend_q <= 1'b0;
    end else if (int_cfg_q[IC_TX_EN] && (data_take || crc_done)) begin
      // (R06) full to empty; (R15) check sent, flag loaded
      // (R08) only a written character can empty the buffer
      tx_pend_q <= 1'b1;
    end else if (cmd_rst_txint || wr_data) begin
      // (R07) cleared; set again by the next taken character or finished check bytes
      tx_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      ext_pend_q <= 1'b0;
    end else if (int_cfg_q[IC_EXT_EN] && underrun && !eom_q) begin
      // (R16) underrun set the latch
      ext_pend_q <= 1'b1;
    end else if (cmd_rst_ext) begin
      ext_pend_q <= 1'b0;
    end
  end

  assign tx_irq  = tx_pend_q;
  assign ext_irq = ext_pend_q;

  // (R09) wait stretches a blocked write, ready while empty
  assign wait_n  = ~(wr_data_req & wr_block);
  assign ready_n = ~(int_cfg_q[IC_WR_EN] & int_cfg_q[IC_WR_READY]
                     & tx_empty & tx_on);

  // ==========================================================
  // status read
  always_ff @(posedge core_clk) begin
    if (clr) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd) begin
      rdata_q <= 8'h00;
      if (cpu_cd) begin
        rdata_q[ST_TX_EMPTY] <= tx_empty;
        rdata_q[ST_INT_PEND] <= tx_pend_q | ext_pend_q;
        rdata_q[ST_EOM]      <= eom_q;
      end
    end
  end

  assign cpu_rdata = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_underrun_open;
    underrun && !eom_q;
  endsequence

  sequence s_check_start;
    kind_q == K_CRC1 && eom_q && crc_busy_q;
  endsequence

  mark_idle_a : assert property (                              // R01
    (kind_q == K_MARK && !txctl_q[TC_BREAK] && !soft_rst) |-> txd)
    else $error("line not marking while idle");

  break_space_a : assert property (                            // R02
    txctl_q[TC_BREAK] |-> !txd)
    else $error("break did not space the line");

  abort_ones_a : assert property (                             // R04
    (tick && abort_go && !cmd_abort && !soft_rst)
      |=> kind_q == K_ABORT && bit_q)
    else $error("abort did not start with ones");

  stuff_zero_a : assert property (                             // R05
    (stuff && !soft_rst) |=> !bit_q && ones_q == 3'h0)
    else $error("no zero after five ones");

  tx_int_a : assert property (                                 // R06
    (data_take && int_cfg_q[IC_TX_EN] && !soft_rst) |=> tx_pend_q)
    else $error("buffer empty interrupt missing");

  first_int_a : assert property (                              // R08
    $rose(tx_pend_q) |-> $past(data_take || crc_done))
    else $error("interrupt without an emptied buffer");

  underrun_crc_a : assert property (                           // R11
    (s_underrun_open and !soft_rst && !cmd_abort)
      |=> s_check_start ##1 eom_q)
    else $error("underrun did not start check bytes");

  eom_flags_a : assert property (                              // R12
    (underrun && eom_q && !buf_full_q && !soft_rst) |=> kind_q == K_FLAG)
    else $error("check bytes sent with latch set");

  crc_busy_a : assert property (                               // R13
    (kind_q == K_CRC1 || kind_q == K_CRC2) && !abort_q |-> !tx_empty)
    else $error("empty status during check bytes");

  ext_int_a : assert property (                                // R16
    (s_underrun_open and int_cfg_q[IC_EXT_EN] && !soft_rst) |=> ext_irq)
    else $error("status interrupt missing on underrun");

  enable_flag_a : assert property (                            // R20
    (load && kind_q == K_MARK && tx_on && !abort_q && !soft_rst)
      |=> kind_q == K_FLAG && sh_q == (FLAG_CHAR >> 1))
    else $error("no flag after enable");

endmodule : sdlct_frame_tx

/* File: sdlct_line_rx.sv */
// remote receiving station model and transmit bit clock source
`timescale 1ns/1ps
module sdlct_line_rx
  import sdlct_pkg::*;
(
  input  wire logic run,
  input  wire logic txd,
  output logic      txc
);
  logic [7:0] h       = 8'h00;
  logic [7:0] cur     = 8'h00;
  int         nb      = 0;
  int         ones    = 0;
  int         max_run = 0;
  int         n_flag  = 0;
  int         tot     = 0;
  int         fbits   = 0;
  logic [7:0] q[$];
  logic [7:0] frame[$];

  // ==========================================================
  // bit clock, 64 ns period
  initial txc = 1'b1;
  always #32 if (run) txc = ~txc;

  // ==========================================================
  // line decoder, bits sampled on the rising clock edge
  always @(posedge txc) begin
    h = {txd, h[7:1]};
    if (h == FLAG_CHAR) begin
      n_flag++;
      if (q.size() > 0) frame = q;
      if (tot > 7) fbits = tot - 7;
      q.delete();
      nb  = 0;
      tot = 0;
    end else if (ones >= 6 && txd) begin
      q.delete();
      nb  = 0;
      tot = 0;
    end else if (!(ones == 5 && !txd)) begin
      cur = {txd, cur[7:1]};
      nb++;
      tot++;
      if (nb == 8) begin
        q.push_back(cur);
        nb = 0;
      end
    end
    ones = txd ? ones + 1 : 0;
    if (ones > max_run) max_run = ones;
  end
endmodule : sdlct_line_rx

/* File: sdlc_frame_transmitter_tb_top.sv */
// self-checking testbench for the sdlc frame transmitter
`timescale 1ns/1ps
module sdlc_frame_transmitter_tb_top;
  import sdlct_pkg::*;
  localparam int LIMIT = 60000;
  logic       core_clk  = 1'b0;
  logic       rst_n     = 1'b0;
  logic       cpu_wr    = 1'b0;
  logic       cpu_rd    = 1'b0;
  logic       cpu_cd    = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic       wait_n;
  logic       ready_n;
  logic       tx_irq;
  logic       ext_irq;
  logic       txc;
  logic       txd;
  logic       rts_n;
  logic       dtr_n;
  logic       blk       = 1'b0;
  logic [7:0] st;
  logic [15:0] crc;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  int         n0;

  always #2.5 core_clk = ~core_clk;

  sdlct_frame_tx i_sdlct_frame_tx (
    .core_clk(core_clk), .rst_n(rst_n), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_cd(cpu_cd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .wait_n(wait_n), .ready_n(ready_n),
    .tx_irq(tx_irq), .ext_irq(ext_irq), .txc(txc), .txd(txd),
    .rts_n(rts_n), .dtr_n(dtr_n)
  );
  sdlct_line_rx i_sdlct_line_rx (.run(1'b1), .txd(txd), .txc(txc));

  // ==========================================================
  // helpers
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, m);
      n_mismatch++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic bits(input int n);
    repeat (n) @(posedge txc);
    tick(1);
  endtask : bits

  task automatic wr(input logic cd, input logic [7:0] d);
    int k;
    cpu_wr = 1'b1;
    cpu_cd = cd;
    cpu_wdata = d;
    #1;
    blk = blk | ~wait_n;
    for (k = 0; k < 4000 && wait_n !== 1'b1; k++) tick(1);
    @(posedge core_clk);
    #1;
    cpu_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic reg_wr(input logic [2:0] p, input logic [7:0] d);
    wr(1'b1, {5'h00, p});
    wr(1'b1, d);
  endtask : reg_wr

  task automatic rd_st();
    cpu_rd = 1'b1;
    cpu_cd = 1'b1;
    tick(1);
    st = cpu_rdata;
    cpu_rd = 1'b0;
    tick(1);
  endtask : rd_st

  task automatic wait_irq(input logic tx);
    int k;
    for (k = 0; k < 4000 && (tx ? tx_irq : ext_irq) !== 1'b1; k++) tick(1);
  endtask : wait_irq

  function automatic logic [15:0] cb(input logic [15:0] c,
                                     input logic [7:0] b);
    int   i;
    logic f;
    for (i = 0; i < 8; i++) begin
      f = c[0] ^ b[i];
      c = c >> 1;
      if (f) c = c ^ CRC_POLY;
    end
    return c;
  endfunction : cb

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(8'(txd), 8'h01, "line not marking after reset");
    chk(8'({tx_irq, ext_irq}), 8'h00, "irq after reset");
    rd_st();
    chk(8'(st[ST_EOM]), 8'h01, "latch clear after reset");
  endtask : t_reset

  task automatic t_enable();
    reg_wr(PTR_MODE, 8'h20);
    reg_wr(PTR_INT_CFG, 8'h03);
    reg_wr(PTR_TX_CTRL, 8'heb);
    chk(8'({rts_n, dtr_n}), 8'h00, "modem outputs");
    bits(4);
    i_sdlct_line_rx.max_run = 0;
    n0 = i_sdlct_line_rx.n_flag;
    bits(40);
    chk(8'(i_sdlct_line_rx.max_run), 8'h06, "idle run");
    chk(8'(i_sdlct_line_rx.n_flag - n0 >= 4), 8'h01, "few flags");
    chk(8'(tx_irq), 8'h00, "empty irq before data");
  endtask : t_enable

  task automatic t_frame();
    crc = cb(cb(CRC_PRESET, 8'hff), 8'h81);
    wr(1'b1, 8'h40);
    wr(1'b0, 8'hff);
    wr(1'b1, 8'hc0);
    wait_irq(1'b1);
    chk(8'(tx_irq), 8'h01, "no empty irq");
    wr(1'b0, 8'h81);
    wait_irq(1'b1);
    wr(1'b1, 8'h28);
    chk(8'(tx_irq), 8'h00, "pending not cleared");
    wait_irq(1'b0);
    chk(8'(ext_irq), 8'h01, "no underrun irq");
    rd_st();
    chk(st & 8'h44, 8'h40, "status during check");
    wait_irq(1'b1);
    chk(8'(tx_irq), 8'h01, "no irq after check");
    bits(12);
    chk(8'(i_sdlct_line_rx.frame.size()), 8'h04, "frame length");
    chk(i_sdlct_line_rx.frame[0], 8'hff, "byte 0");
    chk(i_sdlct_line_rx.frame[1], 8'h81, "byte 1");
    chk(i_sdlct_line_rx.frame[2], ~crc[7:0], "check low");
    chk(i_sdlct_line_rx.frame[3], ~crc[15:8], "check high");
    wr(1'b1, 8'h10);
    chk(8'(ext_irq), 8'h00, "status irq stuck");
  endtask : t_frame

  task automatic t_eom_set();
    wr(1'b0, 8'h55);
    wait_irq(1'b1);
    wr(1'b1, 8'h28);
    bits(30);
    chk(8'(i_sdlct_line_rx.frame.size()), 8'h01, "check sent");
    chk(i_sdlct_line_rx.frame[0], 8'h55, "lone byte");
  endtask : t_eom_set

  task automatic t_length();
    int         i;
    logic [7:0] ctl [3]  = '{8'hab, 8'hcb, 8'h8b};
    int         nbit [3] = '{7, 6, 5};
    for (i = 0; i < 3; i++) begin
      reg_wr(PTR_TX_CTRL, ctl[i]);
      wr(1'b0, 8'h00);
      wait_irq(1'b1);
      wr(1'b1, 8'h28);
      bits(30);
      chk(8'(i_sdlct_line_rx.fbits), 8'(nbit[i]), "char length");
    end
    reg_wr(PTR_TX_CTRL, 8'heb);
  endtask : t_length

  task automatic t_abort();
    i_sdlct_line_rx.max_run = 0;
    wr(1'b0, 8'hff);
    wr(1'b0, 8'hff);
    wr(1'b1, 8'h08);
    n0 = i_sdlct_line_rx.n_flag;
    bits(40);
    chk(8'(i_sdlct_line_rx.max_run >= 8 && i_sdlct_line_rx.max_run < 14),
        8'h01, "abort length");
    chk(8'(i_sdlct_line_rx.frame.size()), 8'h01, "data kept");
    chk(8'(i_sdlct_line_rx.n_flag > n0), 8'h01, "no flags after");
    wr(1'b1, 8'h28);
  endtask : t_abort

  task automatic t_wait();
    int k;
    reg_wr(PTR_INT_CFG, 8'h83);
    blk = 1'b0;
    wr(1'b0, 8'h11);
    wr(1'b0, 8'h22);
    wr(1'b0, 8'h33);
    chk(8'(blk), 8'h01, "write not stretched");
    bits(40);
    chk(8'(i_sdlct_line_rx.frame.size()), 8'h03, "waited frame");
    chk(i_sdlct_line_rx.frame[2], 8'h33, "waited byte");
    reg_wr(PTR_INT_CFG, 8'ha3);
    for (k = 0; k < 4000 && ready_n !== 1'b0; k++) tick(1);
    chk(8'(ready_n), 8'h00, "no ready");
    rd_st();
    chk(8'(st[ST_TX_EMPTY]), 8'h01, "ready not empty");
  endtask : t_wait

  task automatic t_break();
    reg_wr(PTR_TX_CTRL, 8'hfb);
    tick(3);
    chk(8'(txd), 8'h00, "break");
    bits(3);
    chk(8'(txd), 8'h00, "break held");
    reg_wr(PTR_TX_CTRL, 8'h60);
    bits(12);
    chk(8'(txd), 8'h01, "disabled line");
    bits(10);
    chk(8'(txd), 8'h01, "disabled line later");
  endtask : t_break

  task automatic t_chan_rst();
    wr(1'b1, 8'hc0);
    wr(1'b1, 8'h18);
    rd_st();
    chk(8'(st[ST_EOM]), 8'h01, "latch after channel reset");
    chk(8'(txd), 8'h01, "line after channel reset");
  endtask : t_chan_rst

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_enable();
    t_frame();
    t_eom_set();
    t_length();
    t_abort();
    t_wait();
    t_break();
    t_chan_rst();
    stop_test();
  end
endmodule : sdlc_frame_transmitter_tb_top
